// file: hdl/rt_address_and_busy_lookup.sv
// Own-address selection, command match and busy lookup for a 1553 remote terminal.
// Assumes the word decoder supplies command words and a mid-parity pulse on this clock;
// pins come from outside and are synchronised here. Shared RAM is read by the caller.
// Operation
// R1 - Busy address has bits 9 and 6 set; bit 2 marks broadcast.
// R2 - Busy address bit 1 is high for transmit, low for receive.
// R3 - Busy address bit 0 is the subaddress MSB.
// R4 - Bit n of busy word covers subaddress n, or n+16 when MSB set.
// R5 - Selected table bit one sets status busy; zero leaves it alone.
// R6 - Lookup used only with extended mode, table enable, alternate status off.
// R7 - Busy table spans shared RAM words 0x0240 to 0x0247.
// R8 - Non-broadcast response needs address match and odd six-bit parity.
// R9 - Own address valid only with odd ones count including parity.
// R10 - Broadcast address 31 accepted unless broadcast disable set.
// R11 - Own address sampled about 2 us after command mid-parity.
// R12 - Strobe low: internal address follows pins transparently.
// R13 - Strobe rising edge captures pins and holds them afterwards.
// R14 - Software latch: strobe high, extended, source clear, latch bit; write captures pins.
// R15 - Source set: register write loads address from data 5-1, parity data 0.
// R16 - Software should clear latch-on-write after latching the address.
// R17 - Readback gives strobe at bit 6, address bits 5-1, parity bit 0.
// R18 - Bad own parity blocks non-broadcast responses; broadcast unchanged.
`timescale 1ns/1ps
module rt_address_and_busy_lookup (
  // Clock and control
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // Address pins
  input wire logic [rt_addr_pkg::ADDR_W-1:0] own_addr_pins,
  input wire logic own_addr_parity_pin,
  input wire logic addr_latch_strobe,
  // Configuration bits
  input wire logic extended_mode,
  input wire logic addr_source_select,
  input wire logic latch_on_cfg_write,
  input wire logic broadcast_disable,
  input wire logic busy_table_enable,
  input wire logic alt_status_enable,
  // Address register write
  input wire logic addr_reg_write,
  input wire logic [15:0] addr_reg_wdata,
  // Received command
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic mid_parity,
  // Busy word read from shared RAM
  input wire logic busy_word_valid,
  input wire logic [15:0] busy_word,
  // Results
  output logic [15:0] addr_reg_rdata,
  output logic [rt_addr_pkg::ADDR_W-1:0] sampled_addr,
  output logic own_addr_valid,
  output logic cmd_own_match,
  output logic cmd_broadcast,
  output logic busy_lookup_req,
  output logic [15:0] busy_lookup_addr,
  output logic table_busy
);
  import rt_addr_pkg::*;

  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic strobe_s1;
  logic strobe_s2;
  logic strobe_d;
  logic [ADDR_W-1:0] int_addr;
  logic int_par;
  logic sw_latch_ok;
  logic [7:0] sample_cnt;
  logic sample_run;
  logic [ADDR_W-1:0] samp_addr;
  logic samp_par;
  logic [4:0] cmd_addr;
  logic cmd_is_bcast;
  logic lookup_on;
  logic bcast_q;
  logic tr_q;
  logic [4:0] sa_q;
  busy_if bif();

  function automatic logic odd_parity(input logic [ADDR_W-1:0] a, input logic p);
    odd_parity = ^{a, p};
  endfunction : odd_parity

  // Pins are asynchronous to the core clock
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_d <= 1'b0;
    end else if (clk_en) begin
      pin_s1 <= {own_addr_pins, own_addr_parity_pin};
      pin_s2 <= pin_s1;
      strobe_s1 <= addr_latch_strobe;
      strobe_s2 <= strobe_s1;
      strobe_d <= strobe_s2;
    end
  end

  // R14 software latch qualifiers
  assign sw_latch_ok = strobe_s2 && extended_mode && latch_on_cfg_write && addr_reg_write;

  always_ff @(posedge clock) begin
    if (rst) begin
      int_addr <= '0;
      int_par <= 1'b0;
    end else if (clk_en) begin
      if (!strobe_s2) begin
        // R12 transparent follow
        {int_addr, int_par} <= pin_s2;
      end else if (!strobe_d) begin
        // R13 capture on rising edge
        {int_addr, int_par} <= pin_s2;
      end else if (sw_latch_ok && addr_source_select) begin
        // R15 load from written data
        int_addr <= addr_reg_wdata[REG5_ADDR_LSB +: ADDR_W];
        int_par <= addr_reg_wdata[REG5_PAR_BIT];
      end else if (sw_latch_ok) begin
        // R14 capture pins, data ignored
        {int_addr, int_par} <= pin_s2;
      end
    end
  end

  // R17 readback of strobe and internal address
  always_ff @(posedge clock) begin
    if (rst) begin
      addr_reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      addr_reg_rdata <= 16'h0000;
      addr_reg_rdata[REG5_STROBE_BIT] <= strobe_s2;
      addr_reg_rdata[REG5_ADDR_LSB +: ADDR_W] <= int_addr;
      addr_reg_rdata[REG5_PAR_BIT] <= int_par;
    end
  end

  // R11 sample own address after the mid-parity delay
  always_ff @(posedge clock) begin
    if (rst) begin
      sample_cnt <= 8'h00;
      sample_run <= 1'b0;
      samp_addr <= '0;
      samp_par <= 1'b0;
    end else if (clk_en) begin
      if (mid_parity) begin
        sample_run <= 1'b1;
        sample_cnt <= 8'h00;
      end else if (sample_run) begin
        if (sample_cnt == SAMPLE_CNT_MAX) begin
          sample_run <= 1'b0;
          samp_addr <= int_addr;
          samp_par <= int_par;
        end else begin
          sample_cnt <= sample_cnt + 8'h01;
        end
      end
    end
  end

  assign cmd_addr = cmd_word[CMD_ADDR_LSB +: 5];
  assign cmd_is_bcast = (cmd_addr == BCAST_ADDR);
  // R6 lookup gating
  assign lookup_on = extended_mode && busy_table_enable && !alt_status_enable;

  always_ff @(posedge clock) begin
    if (rst) begin
      sampled_addr <= '0;
      own_addr_valid <= 1'b0;
      cmd_own_match <= 1'b0;
      cmd_broadcast <= 1'b0;
    end else if (clk_en) begin
      sampled_addr <= samp_addr;
      // R9 odd parity check
      own_addr_valid <= odd_parity(samp_addr, samp_par);
      if (cmd_valid) begin
        // R8 R18 match only with good parity
        cmd_own_match <= !cmd_is_bcast && cmd_addr == sampled_addr && own_addr_valid;
        // R10 broadcast unless disabled
        cmd_broadcast <= cmd_is_bcast && !broadcast_disable;
      end else begin
        cmd_own_match <= 1'b0;
        cmd_broadcast <= 1'b0;
      end
    end
  end

  // Command fields held for the lookup and the later RAM answer
  always_ff @(posedge clock) begin
    if (rst) begin
      bcast_q <= 1'b0;
      tr_q <= 1'b0;
      sa_q <= 5'h00;
      busy_lookup_req <= 1'b0;
      busy_lookup_addr <= BUSY_TABLE_BASE;
    end else if (clk_en) begin
      busy_lookup_req <= 1'b0;
      if (cmd_valid) begin
        bcast_q <= cmd_is_bcast;
        tr_q <= cmd_word[CMD_TR_BIT];
        sa_q <= cmd_word[CMD_SA_LSB +: SA_W];
        // R6 request only when enabled and accepted
        busy_lookup_req <= lookup_on && ((cmd_is_bcast && !broadcast_disable)
          || (!cmd_is_bcast && cmd_addr == sampled_addr && own_addr_valid));
      end
      // R7 address inside 0x0240..0x0247
      busy_lookup_addr <= bif.lookup_addr;
    end
  end

  assign bif.broadcast_select = bcast_q;
  assign bif.transmit = tr_q;
  assign bif.subaddr = sa_q;
  assign bif.busy_word = busy_word;

  busy_select u_sel (
    .bus(bif.sel)
  );

  // R5 busy from table bit, sticky until the next command
  always_ff @(posedge clock) begin
    if (rst) begin
      table_busy <= 1'b0;
    end else if (clk_en) begin
      // Set wins over clear, so a late busy word is never lost
      if (busy_word_valid && lookup_on && bif.busy_bit) begin
        table_busy <= 1'b1;
      end else if (cmd_valid) begin
        table_busy <= 1'b0;
      end
    end
  end
endmodule : rt_address_and_busy_lookup

// file: hdl/rt_addr_pkg.sv
// Constants for the remote-terminal address and busy lookup block.
// Assumes a 100 MHz core clock and 1553 command words delivered as 16-bit fields.
package rt_addr_pkg;
  localparam int ADDR_W = 5;
  localparam int SA_W = 5;
  localparam int BUSY_ADDR_W = 16;
  localparam logic [4:0] BCAST_ADDR = 5'h1F;
  // Lookup table base: bits 9 and 6 set, giving 0x0240..0x0247
  localparam logic [15:0] BUSY_TABLE_BASE = 16'h0240;
  localparam int BUSY_BCST_BIT = 2;
  localparam int BUSY_TR_BIT = 1;
  localparam int BUSY_SA4_BIT = 0;
  // Address register word layout
  localparam int REG5_STROBE_BIT = 6;
  localparam int REG5_ADDR_LSB = 1;
  localparam int REG5_PAR_BIT = 0;
  // Command word fields
  localparam int CMD_ADDR_LSB = 11;
  localparam int CMD_TR_BIT = 10;
  localparam int CMD_SA_LSB = 5;
  // Own-address sample delay after mid-parity
  localparam int SAMPLE_DELAY_NS = 2000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_CYCLES = SAMPLE_DELAY_NS / CLK_PERIOD_NS;
  localparam logic [7:0] SAMPLE_CNT_MAX = 8'(SAMPLE_CYCLES - 1);
endpackage : rt_addr_pkg

// file: hdl/busy_if.sv
// Carrier between address block and busy selector.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface busy_if;
  logic broadcast_select;
  logic transmit;
  logic [4:0] subaddr;
  logic [15:0] busy_word;
  logic [15:0] lookup_addr;
  logic busy_bit;
  modport ctrl (output broadcast_select, output transmit, output subaddr, output busy_word,
    input lookup_addr, input busy_bit);
  modport sel (input broadcast_select, input transmit, input subaddr, input busy_word,
    output lookup_addr, output busy_bit);
endinterface : busy_if

// file: hdl/busy_select.sv
// Combinational busy lookup address former and busy bit selector.
// Assumes the caller registers its results.
`timescale 1ns/1ps
module busy_select (
  busy_if.sel bus
);
  import rt_addr_pkg::*;
  logic subaddr_msb;
  assign subaddr_msb = bus.subaddr[SA_W-1];
  always_comb begin
    // R1 fixed base bits
    bus.lookup_addr = BUSY_TABLE_BASE;
    // R1 broadcast bit
    bus.lookup_addr[BUSY_BCST_BIT] = bus.broadcast_select;
    // R2 transmit bit
    bus.lookup_addr[BUSY_TR_BIT] = bus.transmit;
    // R3 subaddress MSB
    bus.lookup_addr[BUSY_SA4_BIT] = subaddr_msb;
  end
  // R4 low four bits pick the bit
  assign bus.busy_bit = bus.busy_word[bus.subaddr[3:0]];
endmodule : busy_select

// file: sim/bc_model.sv
// Bus controller model: issues command words with a mid-parity pulse.
// Assumes the bench calls send from a falling clock edge.
`timescale 1ns/1ps
module bc_model (
  // Clock
  input wire logic clock,
  // Command stream
  output logic cmd_valid,
  output logic [15:0] cmd_word,
  output logic mid_parity
);
  initial begin
    cmd_valid = 0;
    cmd_word = 16'hFFFF;
    mid_parity = 0;
  end
  task automatic send(input logic [15:0] w);
    @(negedge clock);
    cmd_valid = 1;
    cmd_word = w;
    mid_parity = 1;
    @(negedge clock);
    cmd_valid = 0;
    // Released word inverted so a stale value never matches
    cmd_word = ~w;
    mid_parity = 0;
  endtask : send
endmodule : bc_model

// file: sim/rt_addr_chk.sv
// Checker on the ports of the address and busy lookup block.
// Assumes no command or busy traffic while clk_en is low.
`timescale 1ns/1ps
module rt_addr_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Inputs
  input wire logic extended_mode,
  input wire logic busy_table_enable,
  input wire logic alt_status_enable,
  input wire logic broadcast_disable,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic busy_word_valid,
  input wire logic [15:0] busy_word,
  // Outputs
  input wire logic [15:0] addr_reg_rdata,
  input wire logic [4:0] sampled_addr,
  input wire logic own_addr_valid,
  input wire logic cmd_own_match,
  input wire logic cmd_broadcast,
  input wire logic busy_lookup_req,
  input wire logic [15:0] busy_lookup_addr,
  input wire logic table_busy
);
  import rt_addr_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [3:0] sa_lo;
  logic lk;
  assign lk = extended_mode && busy_table_enable && !alt_status_enable;
  always_ff @(posedge clock)
    if (cmd_valid) sa_lo <= cmd_word[8:5];
  sequence s_req;
    cmd_valid ##1 busy_lookup_req;
  endsequence
  sequence s_hit;
    cmd_valid ##1 (cmd_own_match || cmd_broadcast);
  endsequence
  lookup_addr_a: assert property (s_req |=>
    busy_lookup_addr == (BUSY_TABLE_BASE | {$past(cmd_broadcast), $past(cmd_word[10], 2), $past(cmd_word[9], 2)}))
    else $error("busy lookup address wrong");
  req_cause_a: assert property (busy_lookup_req |-> $past(cmd_valid) && $past(lk))
    else $error("lookup request without cause");
  req_when_a: assert property (s_hit |-> busy_lookup_req == $past(lk))
    else $error("lookup request missing");
  own_match_a: assert property (cmd_valid |=> cmd_own_match ==
    ($past(cmd_word[15:11]) == $past(sampled_addr) && $past(own_addr_valid) && $past(cmd_word[15:11]) != BCAST_ADDR))
    else $error("own address match wrong");
  bcast_match_a: assert property (cmd_valid |=>
    cmd_broadcast == ($past(cmd_word[15:11]) == BCAST_ADDR && !$past(broadcast_disable)))
    else $error("broadcast match wrong");
  busy_set_a: assert property (busy_word_valid && lk |=>
    table_busy == (($past(table_busy) && !$past(cmd_valid)) || $past(busy_word[sa_lo])))
    else $error("busy bit selection wrong");
  busy_clear_a: assert property (cmd_valid && !(busy_word_valid && lk) |=> !table_busy)
    else $error("busy not cleared by command");
  rdata_zero_a: assert property (addr_reg_rdata[15:7] == 9'h000)
    else $error("readback upper bits set");
endmodule : rt_addr_chk
bind rt_address_and_busy_lookup rt_addr_chk i_chk (.*);

// file: sim/rt_address_and_busy_lookup_tb_top.sv
// Self-checking bench for the address and busy lookup block.
// Assumes the controller model supplies commands; clk_en held high except during the frozen write check.
`timescale 1ns/1ps
module rt_address_and_busy_lookup_tb_top;
  import rt_addr_pkg::*;
  logic clock = 0, rst = 1, clk_en = 1, own_addr_parity_pin = 0, addr_latch_strobe = 0;
  logic extended_mode = 1, addr_source_select = 0, latch_on_cfg_write = 0, broadcast_disable = 0;
  logic busy_table_enable = 1, alt_status_enable = 0, addr_reg_write = 0, busy_word_valid = 0;
  logic [4:0] own_addr_pins = 0, sampled_addr, own = 0;
  logic [15:0] addr_reg_wdata = 0, busy_word = 0, addr_reg_rdata, busy_lookup_addr, cmd_word;
  logic cmd_valid, mid_parity, own_addr_valid, cmd_own_match, cmd_broadcast, busy_lookup_req, table_busy;
  logic ok = 0, p1 = 0, p2 = 0;
  logic [7:0] lf = 8'h60;
  logic [18:0] q[$];
  int err_count = 0, check_count = 0;
  always #5 clock = ~clock;
  rt_address_and_busy_lookup i_dut (.*);
  bc_model i_bc (.*);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic wr_addr(input logic [15:0] d);
    addr_reg_wdata = d;
    addr_reg_write = 1;
    cyc(1);
    addr_reg_write = 0;
    cyc(3);
  endtask : wr_addr
  task automatic cmd(input logic [4:0] a, input logic t, input logic [4:0] sa);
    logic m;
    logic b;
    logic r;
    m = a == own && ok && a != BCAST_ADDR;
    b = a == BCAST_ADDR && !broadcast_disable;
    r = (m | b) & extended_mode & busy_table_enable & !alt_status_enable;
    q.push_back({m, b, r, BUSY_TABLE_BASE | {b, t, sa[4]}});
    i_bc.send({a, t, sa, 5'h00});
  endtask : cmd
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  always @(posedge clock) begin
    p1 <= cmd_valid;
    p2 <= p1;
  end
  // Oldest note first; address lags the match flags by a cycle
  always @(negedge clock) begin
    if (p2) begin
      if (q[0][16]) chk(busy_lookup_addr, q[0][15:0], "lookup_addr");
      q.delete(0);
    end
    if (p1) chk({cmd_own_match, cmd_broadcast, busy_lookup_req}, q[0][18:16], "cmd_result");
  end
  initial begin
    cyc(3000);
    err_count++;
    end_sim();
  end
  initial begin
    cyc(3);
    rst = 0;
    chk(busy_lookup_addr, BUSY_TABLE_BASE, "reset_addr");
    own_addr_pins = 5'h0A;
    own_addr_parity_pin = 1;
    cyc(4);
    chk(addr_reg_rdata, 16'h0015, "transparent");
    addr_latch_strobe = 1;
    cyc(4);
    own_addr_pins = 5'h03;
    own_addr_parity_pin = 0;
    cyc(4);
    chk(addr_reg_rdata, 16'h0055, "hw_latch");
    latch_on_cfg_write = 1;
    wr_addr(16'h003F);
    chk(addr_reg_rdata, 16'h0046, "pin_latch");
    addr_source_select = 1;
    wr_addr(16'h000B);
    latch_on_cfg_write = 0;
    wr_addr(16'h0002);
    chk(addr_reg_rdata, 16'h004B, "data_load");
    cmd(5'h05, 1, 5'h12);
    cyc(150);
    chk(sampled_addr, 5'h00, "early_sample");
    cyc(55);
    own = 5'h05;
    ok = 1;
    chk(sampled_addr, own, "sampled");
    chk(own_addr_valid, 1'b1, "own_valid");
    for (int i = 0; i < 8; i++) begin
      lf = nxt(lf);
      cmd(lf[7] ? own : lf[4:0], lf[5], lf[4:0]);
    end
    for (int i = 0; i < 2; i++) begin
      cmd(own, 0, 5'h12);
      cyc(2);
      busy_word = i ? 16'hFFFB : 16'h0004;
      busy_word_valid = 1;
      cyc(1);
      busy_word_valid = 0;
      chk(table_busy, i == 0, "busy_bit");
    end
    cmd(5'h1F, 1, 5'h03);
    broadcast_disable = 1;
    cmd(5'h1F, 0, 5'h03);
    broadcast_disable = 0;
    alt_status_enable = 1;
    cmd(own, 1, 5'h07);
    alt_status_enable = 0;
    latch_on_cfg_write = 1;
    wr_addr(16'h000A);
    cmd(own, 0, 5'h01);
    cyc(205);
    ok = 0;
    chk(own_addr_valid, 1'b0, "bad_parity");
    cmd(own, 0, 5'h01);
    cmd(5'h1F, 0, 5'h01);
    cyc(4);
    // Frozen clock enable must ignore the write
    clk_en = 0;
    wr_addr(16'h0003);
    chk(addr_reg_rdata, 16'h004A, "frozen");
    clk_en = 1;
    cyc(2);
    end_sim();
  end
endmodule : rt_address_and_busy_lookup_tb_top
